//--- hdl/dpac_capture.sv
// Address and command capture for two ports sharing one command clock.
// Functional notes
// - Port 0 captured on command clock rise.
// - Port 1 captured on command clock fall.
// - Wide mode decodes 21 address bits.
// - Narrow mode decodes 22 address bits.
// - Reserved address pins fully ignored.
// - Parity error flag low until cleared.
// - Undo address inversion before decode, parity.
// - Load strobe high ignores new commands.
// - Read/write select combined with load strobe.
`timescale 1ns/100ps
module dpac_capture (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    input  wire logic                   wide36,
    input  wire logic                   errClear,
    input  wire dpac_pkg::dpac_pins_t   pins,
    output dpac_pkg::dpac_cmd_t [1:0]   portCmd,
    output logic                        parity_err_n
);
    import dpac_pkg::*;

    dpac_pins_t        pinS2;
    dpac_pins_t        pinS3;
    logic              ckLevel;
    logic              riseEv;
    logic              fallEv;
    logic [ADDR_W-1:0] usedMask;
    logic [ADDR_W-1:0] addrFix;
    logic              parityFix;
    logic              parityBad;
    logic [1:0]        portEv;
    logic [1:0]        portLoad;
    logic [1:0]        portWrite;
    logic              errSet;

    // All controller pins cross into mclk together so they stay aligned.
    dpac_sync #(
        .W      (PINS_W)
    ) u_sync (
        .mclk   (mclk),
        .rst    (rst),
        .ce     (ce),
        .din    (pins),
        .stage2 (pinS2),
        .stage3 (pinS3)
    );

    // A clock edge counts only once two stages agree on the new level.
    always_comb begin
        riseEv = pinS2.ck && pinS3.ck && !ckLevel;
        fallEv = !pinS2.ck && !pinS3.ck && ckLevel;
    end

    // Agreed level of the command clock, updated on every counted edge.
    always_ff @(posedge mclk) begin
        if (rst) begin
            ckLevel <= CK_LEVEL_RESET;
        end else if (ce && (riseEv || fallEv)) begin
            ckLevel <= pinS3.ck;
        end
    end

    // Decode the stable address: remove inversion, then mask reserved pins.
    // Masking after the inversion keeps floating reserved pins out of both paths.
    always_comb begin
        usedMask  = wide36 ? MASK_X36 : MASK_X18;
        addrFix   = (pinS3.addr[ADDR_W-1:0] ^ {ADDR_W{pinS3.addr_invert_in}})
                    & usedMask;
        parityFix = pinS3.addr_parity_in ^ pinS3.addr_invert_in;
        parityBad = (^addrFix) ^ parityFix;
    end

    // Per-port view: the same bus means port 0 at a rise, port 1 at a fall.
    always_comb begin
        portEv    = {fallEv, riseEv};
        portLoad  = {!pinS3.load_port1_n, !pinS3.load_port0_n};
        portWrite = {!pinS3.rdwr_port1_n, !pinS3.rdwr_port0_n};
    end

    // One capture register per port; valid is a one-cycle pulse per command.
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        always_ff @(posedge mclk) begin
            if (rst) begin
                portCmd[p] <= '0;
            end else if (ce) begin
                portCmd[p].valid <= portEv[p] && portLoad[p];
                if (portEv[p] && portLoad[p]) begin
                    portCmd[p].write  <= portWrite[p];
                    portCmd[p].addr   <= addrFix;
                    portCmd[p].parErr <= parityBad;
                end
            end
        end
    end

    // Any accepted command with bad parity raises the shared flag.
    always_comb begin
        errSet = |(portEv & portLoad) && parityBad;
    end

    // Sticky active-low flag; a new error wins over a clear in the same cycle.
    always_ff @(posedge mclk) begin
        if (rst) begin
            parity_err_n <= PERR_N_RESET;
        end else if (ce) begin
            if (errSet) begin
                parity_err_n <= 1'h0;
            end else if (errClear) begin
                parity_err_n <= 1'h1;
            end
        end
    end

    a_port0_rise_take: assert property (@(posedge mclk) disable iff (rst)
        ce && riseEv && !pinS3.load_port0_n |=> portCmd[0].valid && !portCmd[1].valid)
        else $error("Port 0 command not taken at clock rise.");

    a_port1_fall_take: assert property (@(posedge mclk) disable iff (rst)
        ce && fallEv && !pinS3.load_port1_n |=> portCmd[1].valid && !portCmd[0].valid)
        else $error("Port 1 command not taken at clock fall.");

    a_wide_addr_mask: assert property (@(posedge mclk) disable iff (rst)
        ce && riseEv && wide36 && !pinS3.load_port0_n |=> portCmd[0].addr[ADDR_W-1] == 1'h0)
        else $error("Wide mode captured a reserved address bit.");

    a_narrow_addr_keep: assert property (@(posedge mclk) disable iff (rst)
        ce && riseEv && !wide36 && !pinS3.load_port0_n |=>
        portCmd[0].addr == ($past(pinS3.addr[ADDR_W-1:0]) ^ {ADDR_W{$past(pinS3.addr_invert_in)}}))
        else $error("Narrow mode address not captured in full.");

    a_load_ignore_cmd: assert property (@(posedge mclk) disable iff (rst)
        ce && !(riseEv && !pinS3.load_port0_n) |=> !portCmd[0].valid)
        else $error("Port 0 command taken without load strobe.");

    a_rdwr_decode: assert property (@(posedge mclk) disable iff (rst)
        ce && fallEv && !pinS3.load_port1_n |=> portCmd[1].write == !$past(pinS3.rdwr_port1_n))
        else $error("Port 1 read/write decoded wrongly.");

    a_parity_flag_set: assert property (@(posedge mclk) disable iff (rst)
        ce && riseEv && !pinS3.load_port0_n && parityBad |=> !parity_err_n && portCmd[0].parErr)
        else $error("Parity error did not set the flag.");

    a_flag_sticky: assert property (@(posedge mclk) disable iff (rst)
        !parity_err_n && !(ce && errClear) |=> !parity_err_n)
        else $error("Parity error flag released without a clear.");

    a_flag_clear: assert property (@(posedge mclk) disable iff (rst)
        ce && errClear && !errSet |=> parity_err_n)
        else $error("Parity error flag not cleared.");

    a_inverted_parity_ok: assert property (@(posedge mclk) disable iff (rst)
        ce && riseEv && !pinS3.load_port0_n && pinS3.addr_invert_in
        && ((^(~pinS3.addr[ADDR_W-1:0] & usedMask)) == !pinS3.addr_parity_in)
        |=> !portCmd[0].parErr)
        else $error("Inverted address with good parity flagged.");

    // The idle port sees the opposite strobe level, so a wrong-edge capture shows here.
    a_port1_load_ignore: assert property (@(posedge mclk) disable iff (rst)
        ce && !(fallEv && !pinS3.load_port1_n) |=> !portCmd[1].valid)
        else $error("Port 1 command taken without load strobe.");

    // Port 0 direction comes from its own select, sampled at the rise.
    a_port0_rdwr_decode: assert property (@(posedge mclk) disable iff (rst)
        ce && riseEv && !pinS3.load_port0_n |=> portCmd[0].write == !$past(pinS3.rdwr_port0_n))
        else $error("Port 0 read/write decoded wrongly.");

    // A bad falling-edge command must reach the shared flag as well.
    a_port1_parity_flag: assert property (@(posedge mclk) disable iff (rst)
        ce && fallEv && !pinS3.load_port1_n && parityBad |=> !parity_err_n && portCmd[1].parErr)
        else $error("Port 1 parity error did not set the flag.");

    // Narrow mode keeps every used bit on port 1 too.
    a_port1_addr_keep: assert property (@(posedge mclk) disable iff (rst)
        ce && fallEv && !wide36 && !pinS3.load_port1_n |=>
        portCmd[1].addr == ($past(pinS3.addr[ADDR_W-1:0]) ^ {ADDR_W{$past(pinS3.addr_invert_in)}}))
        else $error("Port 1 narrow address not captured in full.");

    // Wide mode still keeps the low used bits intact after de-inversion.
    a_wide_addr_keep: assert property (@(posedge mclk) disable iff (rst)
        ce && riseEv && wide36 && !pinS3.load_port0_n |=> portCmd[0].addr[ADDR_W36-1:0] ==
        ($past(pinS3.addr[ADDR_W36-1:0]) ^ {ADDR_W36{$past(pinS3.addr_invert_in)}}))
        else $error("Wide mode used address bits not captured.");

    // Refused commands leave the last accepted fields untouched on port 0.
    a_port0_hold_idle: assert property (@(posedge mclk) disable iff (rst)
        ce && !(riseEv && !pinS3.load_port0_n) |=>
        $stable(portCmd[0].addr) && $stable(portCmd[0].write) && $stable(portCmd[0].parErr))
        else $error("Port 0 fields changed without a command.");

    // Refused commands leave the last accepted fields untouched on port 1.
    a_port1_hold_idle: assert property (@(posedge mclk) disable iff (rst)
        ce && !(fallEv && !pinS3.load_port1_n) |=>
        $stable(portCmd[1].addr) && $stable(portCmd[1].write) && $stable(portCmd[1].parErr))
        else $error("Port 1 fields changed without a command.");

    // One rise gives exactly one pulse, since the agreed level moves at once.
    a_port0_pulse_once: assert property (@(posedge mclk) disable iff (rst)
        ce && portCmd[0].valid |=> !portCmd[0].valid)
        else $error("Port 0 valid lasted more than one cycle.");

    // One fall gives exactly one pulse.
    a_port1_pulse_once: assert property (@(posedge mclk) disable iff (rst)
        ce && portCmd[1].valid |=> !portCmd[1].valid)
        else $error("Port 1 valid lasted more than one cycle.");

    // The flag only falls for an accepted command with bad parity.
    a_flag_no_false: assert property (@(posedge mclk) disable iff (rst)
        ce && !errSet && parity_err_n |=> parity_err_n)
        else $error("Parity error flag fell without a bad command.");

    // A clear arriving with a fresh error must not hide that error.
    a_set_beats_clear: assert property (@(posedge mclk) disable iff (rst)
        ce && errSet && errClear |=> !parity_err_n)
        else $error("Clear won over a new parity error.");

    // With the enable low even a clear request is held off.
    a_freeze_flag: assert property (@(posedge mclk) disable iff (rst)
        !ce |=> $stable(parity_err_n))
        else $error("Parity error flag moved while frozen.");

    // With the enable low no command fields may move.
    a_freeze_cmd: assert property (@(posedge mclk) disable iff (rst)
        !ce |=> $stable(portCmd))
        else $error("Port commands moved while frozen.");

endmodule : dpac_capture

//--- hdl/dpac_pkg.sv
// Shared constants and carriers for the dual-port address and command capture block.
package dpac_pkg;

    // Address pins on the shared bus, and the widest decoded address.
    localparam int ADDR_PINS  = 25;
    localparam int ADDR_W     = 22;
    // Decoded address widths for the wide and the narrow data configuration.
    localparam int ADDR_W36   = 21;
    localparam int ADDR_W18   = 22;
    // Number of logical ports sharing the command clock.
    localparam int NUM_PORTS  = 2;
    // Address masks for the two data configurations.
    localparam logic [ADDR_W-1:0] MASK_X36 = 22'h1fffff;
    localparam logic [ADDR_W-1:0] MASK_X18 = 22'h3fffff;
    // Reset values of the parity flag output and the agreed command clock level.
    localparam logic PERR_N_RESET = 1'h1;
    localparam logic CK_LEVEL_RESET = 1'h0;

    // Raw pins from the memory controller, all outside the mclk domain.
    typedef struct packed {
        logic                 ck;
        logic [ADDR_PINS-1:0] addr;
        logic                 addr_parity_in;
        logic                 addr_invert_in;
        logic                 load_port0_n;
        logic                 load_port1_n;
        logic                 rdwr_port0_n;
        logic                 rdwr_port1_n;
    } dpac_pins_t;

    // One captured command for one port.
    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic              parErr;
    } dpac_cmd_t;

    localparam int PINS_W = $bits(dpac_pins_t);

endpackage : dpac_pkg

//--- hdl/dpac_sync.sv
// Three-stage synchroniser for a bundle of asynchronous pins.
`timescale 1ns/100ps
module dpac_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] stage2,
    output logic      [W-1:0] stage3
);
    import dpac_pkg::*;

    // Each bit is its own chain; the first stage feeds only the second.
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic stage1;
        always_ff @(posedge mclk) begin
            if (rst) begin
                stage1    <= 1'h0;
                stage2[i] <= 1'h0;
                stage3[i] <= 1'h0;
            end else if (ce) begin
                stage1    <= din[i];
                stage2[i] <= stage1;
                stage3[i] <= stage2[i];
            end
        end
    end

endmodule : dpac_sync

//--- tb/dpac_ctrl_model.sv
// Memory controller model that drives the command clock, address and strobes.
`timescale 1ns/100ps
module dpac_ctrl_model (
    input  wire logic            mclk,
    input  wire logic            wide36,
    output dpac_pkg::dpac_pins_t pins
);
    import dpac_pkg::*;
    logic [ADDR_PINS-1:0] junk = 25'haaaaaa;
    initial pins = '0;
    // One call is one half-cycle: set up, flip ck, then hold past the edge.
    // The idle port's strobes get the opposite value, so sampling on the wrong edge shows.
    task automatic send(input logic [ADDR_W-1:0] a, input logic ldN, rwN, inv, bad);
        logic [ADDR_PINS-1:0] u;
        u = wide36 ? 25'(MASK_X36) : 25'(MASK_X18);
        junk = ~junk;
        pins.addr = (({3'h0, a} ^ {25{inv}}) & u) | (junk & ~u);
        pins.addr_parity_in = ^({3'h0, a} & u) ^ bad ^ inv;
        pins.addr_invert_in = inv;
        pins.load_port0_n = pins.ck ? ~ldN : ldN;
        pins.load_port1_n = pins.ck ? ldN : ~ldN;
        pins.rdwr_port0_n = pins.ck ? ~rwN : rwN;
        pins.rdwr_port1_n = pins.ck ? rwN : ~rwN;
        repeat (4) @(posedge mclk);
        #1 pins.ck = ~pins.ck;
        repeat (6) @(posedge mclk);
        #1;
    endtask : send
endmodule : dpac_ctrl_model

//--- tb/tb_top.sv
// Self-checking bench for the dual-port address and command capture block.
`timescale 1ns/100ps
module tb_top;
    import dpac_pkg::*;
    logic            mclk = 1'h0;
    logic            rst = 1'h1;
    logic            ce = 1'h1;
    logic            wide36 = 1'h0;
    logic            errClear = 1'h0;
    dpac_pins_t      pins;
    dpac_cmd_t [1:0] portCmd;
    logic            parity_err_n;
    dpac_cmd_t       last [2];
    int              vcnt [2] = '{0, 0};
    int              error_cnt = 0;
    int              n_checks = 0;
    // Clock of 200 MHz.
    always #2.5 mclk = ~mclk;
    dpac_capture i_dpac_capture (.mclk(mclk), .rst(rst), .ce(ce), .wide36(wide36),
        .errClear(errClear), .pins(pins), .portCmd(portCmd), .parity_err_n(parity_err_n));
    dpac_ctrl_model i_dpac_ctrl_model (.mclk(mclk), .wide36(wide36), .pins(pins));
    // Latch each accepted command; a pulse lasts one cycle, so it is caught here.
    always @(posedge mclk) begin
        for (int p = 0; p < 2; p++) begin
            if (portCmd[p].valid === 1'h1) begin
                last[p] <= portCmd[p];
                vcnt[p] <= vcnt[p] + 1;
            end
        end
    end
    task automatic cmp1(input string s, input logic e, g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s exp %h got %h", s, e, g);
        end
    endtask : cmp1
    task automatic cmpA(input string s, input logic [ADDR_W-1:0] e, g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s exp %h got %h", s, e, g);
        end
    endtask : cmpA
    // Send one half-cycle command and judge what the port reports for it.
    task automatic step(input logic [ADDR_W-1:0] a, input logic ldN, rwN, inv, bad);
        int p = int'(pins.ck);
        int n = vcnt[p];
        int m = vcnt[1 - p];
        i_dpac_ctrl_model.send(a, ldN, rwN, inv, bad);
        cmp1("count", 1'h1, vcnt[p] == n + int'(!ldN));
        cmp1("idle count", 1'h1, vcnt[1 - p] == m);
        if (!ldN) begin
            cmpA("addr", a & (wide36 ? MASK_X36 : MASK_X18), last[p].addr);
            cmp1("write", !rwN, last[p].write);
            cmp1("parErr", bad, last[p].parErr);
        end
    endtask : step
    task automatic t_narrow;
        wide36 = 1'h0;
        step(22'h3fffff, 1'h0, 1'h0, 1'h0, 1'h0);
        step(22'h2aaaa5, 1'h0, 1'h1, 1'h0, 1'h0);
        cmp1("perr_n", 1'h1, parity_err_n);
    endtask : t_narrow
    task automatic t_wide;
        wide36 = 1'h1;
        step(22'h3fffff, 1'h0, 1'h1, 1'h0, 1'h0);
        step(22'h155555, 1'h0, 1'h0, 1'h0, 1'h0);
        cmp1("perr_n", 1'h1, parity_err_n);
    endtask : t_wide
    task automatic t_inv;
        step(22'h0f0f0f, 1'h0, 1'h0, 1'h1, 1'h0);
        wide36 = 1'h0;
        step(22'h30f0f1, 1'h0, 1'h1, 1'h1, 1'h0);
        cmp1("perr_n", 1'h1, parity_err_n);
    endtask : t_inv
    task automatic t_load;
        step(22'h123456, 1'h1, 1'h0, 1'h0, 1'h1);
        step(22'h000001, 1'h1, 1'h1, 1'h0, 1'h1);
        cmp1("perr_n", 1'h1, parity_err_n);
    endtask : t_load
    task automatic t_perr;
        step(22'h000003, 1'h0, 1'h0, 1'h0, 1'h1);
        cmp1("perr_n", 1'h0, parity_err_n);
        step(22'h000004, 1'h0, 1'h0, 1'h0, 1'h0);
        cmp1("perr_n", 1'h0, parity_err_n);
        errClear = 1'h1;
        @(posedge mclk);
        #1 errClear = 1'h0;
        cmp1("perr_n", 1'h1, parity_err_n);
        step(22'h000005, 1'h0, 1'h1, 1'h0, 1'h0);
        step(22'h000007, 1'h0, 1'h1, 1'h0, 1'h1);
        cmp1("perr_n", 1'h0, parity_err_n);
    endtask : t_perr
    // Enable low holds the flag through a clear; an error beats a clear in one cycle.
    task automatic t_flag;
        step(22'h000002, 1'h0, 1'h0, 1'h0, 1'h1);
        ce = 1'h0;
        errClear = 1'h1;
        repeat (2) @(posedge mclk);
        #1 ce = 1'h1;
        cmp1("perr_n frozen", 1'h0, parity_err_n);
        @(posedge mclk);
        #1 errClear = 1'h0;
        cmp1("perr_n", 1'h1, parity_err_n);
        fork
            step(22'h000006, 1'h0, 1'h1, 1'h0, 1'h1);
            begin
                repeat (7) @(posedge mclk);
                #1 errClear = 1'h1;
                @(posedge mclk);
                #1 errClear = 1'h0;
            end
        join
        cmp1("perr_n set wins", 1'h0, parity_err_n);
    endtask : t_flag
    task automatic final_report;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    // Reset for 8 cycles, then run every scenario in turn.
    initial begin
        repeat (8) @(posedge mclk);
        #1 rst = 1'h0;
        cmp1("perr_n", 1'h1, parity_err_n);
        t_narrow();
        t_wide();
        t_inv();
        t_load();
        t_perr();
        t_flag();
        final_report();
    end
    // Watchdog: the scenarios need about 0.8 us, so 5 us means a hang.
    initial begin
        #5000;
        error_cnt++;
        final_report();
    end
endmodule : tb_top
